/* File: design/pmr_pkg.sv */
package pmr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_ID_HIGH = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ID_LOW  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CTRL1   = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CTRL2   = 8'h0c;

	// power_monitor_control_1 field positions
	localparam int C1_WARN_FLAG = 7;
	localparam int C1_WARN_ACK  = 6;
	localparam int C1_IRQ_EN    = 5;
	localparam int C1_DRST_EN   = 4;
	localparam int C1_STOP_EN   = 3;
	localparam int C1_DET_EN    = 2;
	localparam int C1_REF_BUF   = 0;

	// power_monitor_control_2 field positions
	localparam int C2_DET_LVL   = 5;
	localparam int C2_WARN_LVL  = 4;
	localparam int C2_PPD_FLAG  = 3;
	localparam int C2_PPD_ACK   = 2;
	localparam int C2_PPD_MODE  = 0;

	// reset values
	localparam logic RST_DRST_EN  = 1'b1;
	localparam logic RST_DET_EN   = 1'b1;
	localparam logic RST_STOP_EN  = 1'b0;
	localparam logic RST_IRQ_EN   = 1'b0;
	localparam logic RST_REF_BUF  = 1'b0;
	localparam logic RST_DET_LVL  = 1'b0;
	localparam logic RST_WARN_LVL = 1'b0;
	localparam logic RST_PPD_MODE = 1'b0;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESP    = 2'b10
	} pmr_wr_state_type;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} pmr_rd_state_type;

	typedef struct packed {
		logic warn_flag;
		logic irq_en;
		logic stop_en;
		logic ref_buf;
		logic ppd_flag;
	} pmr_ctrl_type;

	localparam pmr_ctrl_type CTRL_RST = '{
		warn_flag: 1'b0,
		irq_en:    RST_IRQ_EN,
		stop_en:   RST_STOP_EN,
		ref_buf:   RST_REF_BUF,
		ppd_flag:  1'b0
	};
endpackage

/* File: design/pmr_sync3.sv */
`timescale 1ns/100ps
module pmr_sync3 (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_d,
	output logic      o_q
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic q_r;
	logic q_nxt;

	// a change only counts once two later stages agree
	always_comb begin
		q_nxt = (s2_r == s3_r) ? s3_r : q_r;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			q_r  <= 1'b0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= q_nxt;
		end
	end

	assign o_q = q_r;
endmodule // pmr_sync3

/* File: design/pmr_wonce.sv */
`timescale 1ns/100ps
module pmr_wonce #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_rst_lock,
	input  wire logic i_rst_val,
	input  wire logic i_wr,
	input  wire logic i_d,
	output logic      o_q
);
	logic lock_r;
	logic lock_nxt;
	logic q_r;
	logic q_nxt;

	always_comb begin
		lock_nxt = lock_r | i_wr;
		q_nxt    = (i_wr && !lock_r) ? i_d : q_r;
	end

	always_ff @(posedge i_clk or posedge i_rst_lock) begin
		if (i_rst_lock) begin
			lock_r <= 1'b0;
		end else begin
			lock_r <= lock_nxt;
		end
	end

	// value may keep a separate reset so some resets leave it alone
	always_ff @(posedge i_clk or posedge i_rst_val) begin
		if (i_rst_val) begin
			q_r <= RST_VAL;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_q = q_r;
endmodule // pmr_wonce

/* File: design/pmr_power_monitor.sv */
`timescale 1ns/100ps
module pmr_power_monitor
	import pmr_pkg::*;
#(
	parameter logic [7:0] PART_ID_LOW  = 8'h5a, // arbitrary value
	parameter logic [3:0] PART_ID_HIGH = 4'h3   // arbitrary value
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_por,
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	input  wire logic [ADDR_W-1:0] i_araddr,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	output logic [31:0]            o_rdata,
	output logic [1:0]             o_rresp,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	input  wire logic              i_warn_active,
	input  wire logic              i_detect_event,
	input  wire logic              i_in_stop,
	input  wire logic              i_ppd_wake,
	output logic                   o_warn_irq,
	output logic                   o_detect_reset_req,
	output logic                   o_detect_active,
	output logic                   o_ref_buffer_en,
	output logic                   o_detect_level_select,
	output logic                   o_warning_level_select,
	output logic                   o_powerdown_mode_select
);
	logic              rst_any;
	logic              warn_s;
	logic              det_s;
	pmr_wr_state_type  wr_state_r;
	pmr_wr_state_type  wr_state_nxt;
	logic              awready_r;
	logic              awready_nxt;
	logic              wready_r;
	logic              wready_nxt;
	logic              aw_held_r;
	logic              aw_held_nxt;
	logic              w_held_r;
	logic              w_held_nxt;
	logic [ADDR_W-1:0] waddr_r;
	logic [ADDR_W-1:0] waddr_nxt;
	logic [7:0]        wdata_r;
	logic [7:0]        wdata_nxt;
	logic              wstrb0_r;
	logic              wstrb0_nxt;
	logic              bvalid_r;
	logic              bvalid_nxt;
	logic [1:0]        bresp_r;
	logic [1:0]        bresp_nxt;
	pmr_rd_state_type  rd_state_r;
	pmr_rd_state_type  rd_state_nxt;
	logic              arready_r;
	logic              arready_nxt;
	logic              rvalid_r;
	logic              rvalid_nxt;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic [1:0]        rresp_r;
	logic [1:0]        rresp_nxt;
	logic              wr_en;
	logic              wr_c1;
	logic              wr_c2;
	logic              mapped_w;
	logic              mapped_r;
	logic [7:0]        rd_byte;
	pmr_ctrl_type      ctrl_r;
	pmr_ctrl_type      ctrl_nxt;
	logic              warn_lvl_r;
	logic              warn_lvl_nxt;
	logic              drst_en;
	logic              det_en;
	logic              det_lvl;
	logic              ppd_mode;
	logic              irq_r;
	logic              irq_nxt;
	logic              det_act_r;
	logic              det_act_nxt;
	logic              rst_req_r;
	logic              rst_req_nxt;
	logic              c1_seen_r;
	logic              c2_seen_r;
	logic              rd_is_idlo;

	// either reset restarts the write-once locks and the bus
	assign rst_any = i_rst | i_por;

	pmr_sync3 u_sync_warn (
		.i_clk (i_clk),
		.i_rst (rst_any),
		.i_d   (i_warn_active),
		.o_q   (warn_s)
	);

	pmr_sync3 u_sync_det (
		.i_clk (i_clk),
		.i_rst (rst_any),
		.i_d   (i_detect_event),
		.o_q   (det_s)
	);

	// ---- write channel ----
	always_comb begin
		wr_state_nxt = wr_state_r;
		awready_nxt  = awready_r;
		wready_nxt   = wready_r;
		aw_held_nxt  = aw_held_r;
		w_held_nxt   = w_held_r;
		waddr_nxt    = waddr_r;
		wdata_nxt    = wdata_r;
		wstrb0_nxt   = wstrb0_r;
		bvalid_nxt   = bvalid_r;
		bresp_nxt    = bresp_r;
		wr_en        = 1'b0;
		case (wr_state_r)
			WR_COLLECT: begin
				if (i_awvalid && awready_r) begin
					aw_held_nxt = 1'b1;
					awready_nxt = 1'b0;
					waddr_nxt   = i_awaddr;
				end
				if (i_wvalid && wready_r) begin
					w_held_nxt = 1'b1;
					wready_nxt = 1'b0;
					wdata_nxt  = i_wdata[7:0];
					wstrb0_nxt = i_wstrb[0];
				end
				if (aw_held_r && w_held_r) begin
					wr_en        = 1'b1;
					aw_held_nxt  = 1'b0;
					w_held_nxt   = 1'b0;
					bvalid_nxt   = 1'b1;
					bresp_nxt    = mapped_w ? RESP_OKAY : RESP_SLVERR;
					wr_state_nxt = WR_RESP;
				end
			end
			WR_RESP: begin
				if (i_bready) begin
					bvalid_nxt   = 1'b0;
					awready_nxt  = 1'b1;
					wready_nxt   = 1'b1;
					wr_state_nxt = WR_COLLECT;
				end
			end
			default: begin
				wr_state_nxt = WR_COLLECT;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge rst_any) begin
		if (rst_any) begin
			wr_state_r <= WR_COLLECT;
			awready_r  <= 1'b1;
			wready_r   <= 1'b1;
			aw_held_r  <= 1'b0;
			w_held_r   <= 1'b0;
			waddr_r    <= '0;
			wdata_r    <= '0;
			wstrb0_r   <= 1'b0;
			bvalid_r   <= 1'b0;
			bresp_r    <= RESP_OKAY;
		end else begin
			wr_state_r <= wr_state_nxt;
			awready_r  <= awready_nxt;
			wready_r   <= wready_nxt;
			aw_held_r  <= aw_held_nxt;
			w_held_r   <= w_held_nxt;
			waddr_r    <= waddr_nxt;
			wdata_r    <= wdata_nxt;
			wstrb0_r   <= wstrb0_nxt;
			bvalid_r   <= bvalid_nxt;
			bresp_r    <= bresp_nxt;
		end
	end

	// id registers answer OKAY but store nothing
	assign mapped_w = (waddr_r == ADDR_ID_HIGH) || (waddr_r == ADDR_ID_LOW) ||
		(waddr_r == ADDR_CTRL1) || (waddr_r == ADDR_CTRL2);
	assign wr_c1 = wr_en && wstrb0_r && (waddr_r == ADDR_CTRL1);
	assign wr_c2 = wr_en && wstrb0_r && (waddr_r == ADDR_CTRL2);

	// ---- read channel ----
	assign mapped_r = (i_araddr == ADDR_ID_HIGH) || (i_araddr == ADDR_ID_LOW) ||
		(i_araddr == ADDR_CTRL1) || (i_araddr == ADDR_CTRL2);
	assign rd_is_idlo = (i_araddr == ADDR_ID_LOW);

	always_comb begin
		case (i_araddr)
			ADDR_ID_HIGH: rd_byte = {4'h0, PART_ID_HIGH};
			ADDR_ID_LOW:  rd_byte = PART_ID_LOW;
			ADDR_CTRL1:   rd_byte = {ctrl_r.warn_flag, 1'b0, ctrl_r.irq_en, drst_en,
				ctrl_r.stop_en, det_en, 1'b0, ctrl_r.ref_buf};
			ADDR_CTRL2:   rd_byte = {2'b00, det_lvl, warn_lvl_r, ctrl_r.ppd_flag,
				2'b00, ppd_mode};
			default:      rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		rd_state_nxt = rd_state_r;
		arready_nxt  = arready_r;
		rvalid_nxt   = rvalid_r;
		rdata_nxt    = rdata_r;
		rresp_nxt    = rresp_r;
		case (rd_state_r)
			RD_IDLE: begin
				if (i_arvalid && arready_r) begin
					arready_nxt  = 1'b0;
					rvalid_nxt   = 1'b1;
					rdata_nxt    = {24'h000000, rd_byte};
					rresp_nxt    = mapped_r ? RESP_OKAY : RESP_SLVERR;
					rd_state_nxt = RD_RESP;
				end
			end
			RD_RESP: begin
				if (i_rready) begin
					rvalid_nxt   = 1'b0;
					arready_nxt  = 1'b1;
					rd_state_nxt = RD_IDLE;
				end
			end
			default: begin
				rd_state_nxt = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge rst_any) begin
		if (rst_any) begin
			rd_state_r <= RD_IDLE;
			arready_r  <= 1'b1;
			rvalid_r   <= 1'b0;
			rdata_r    <= '0;
			rresp_r    <= RESP_OKAY;
		end else begin
			rd_state_r <= rd_state_nxt;
			arready_r  <= arready_nxt;
			rvalid_r   <= rvalid_nxt;
			rdata_r    <= rdata_nxt;
			rresp_r    <= rresp_nxt;
		end
	end

	// ---- write-once fields ----
	pmr_wonce #(.RST_VAL(RST_DRST_EN)) u_drst_en (
		.i_clk      (i_clk),
		.i_rst_lock (rst_any),
		.i_rst_val  (rst_any),
		.i_wr       (wr_c1),
		.i_d        (wdata_r[C1_DRST_EN]),
		.o_q        (drst_en)
	);

	pmr_wonce #(.RST_VAL(RST_DET_EN)) u_det_en (
		.i_clk      (i_clk),
		.i_rst_lock (rst_any),
		.i_rst_val  (rst_any),
		.i_wr       (wr_c1),
		.i_d        (wdata_r[C1_DET_EN]),
		.o_q        (det_en)
	);

	// detect level survives every reset except power-on
	pmr_wonce #(.RST_VAL(RST_DET_LVL)) u_det_lvl (
		.i_clk      (i_clk),
		.i_rst_lock (rst_any),
		.i_rst_val  (i_por),
		.i_wr       (wr_c2),
		.i_d        (wdata_r[C2_DET_LVL]),
		.o_q        (det_lvl)
	);

	pmr_wonce #(.RST_VAL(RST_PPD_MODE)) u_ppd_mode (
		.i_clk      (i_clk),
		.i_rst_lock (rst_any),
		.i_rst_val  (rst_any),
		.i_wr       (wr_c2),
		.i_d        (wdata_r[C2_PPD_MODE]),
		.o_q        (ppd_mode)
	);

	// ---- status and control ----
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_c1) begin
			ctrl_nxt.irq_en  = wdata_r[C1_IRQ_EN];
			ctrl_nxt.stop_en = wdata_r[C1_STOP_EN];
			ctrl_nxt.ref_buf = wdata_r[C1_REF_BUF];
		end
		// level set also catches a warning already present after reset; set wins
		ctrl_nxt.warn_flag = warn_s |
			(ctrl_r.warn_flag & ~(wr_c1 & wdata_r[C1_WARN_ACK]));
		ctrl_nxt.ppd_flag = i_ppd_wake |
			(ctrl_r.ppd_flag & ~(wr_c2 & wdata_r[C2_PPD_ACK]));
		warn_lvl_nxt = wr_c2 ? wdata_r[C2_WARN_LVL] : warn_lvl_r;
		irq_nxt      = ctrl_nxt.irq_en & ctrl_nxt.warn_flag;
		det_act_nxt  = det_en & (~i_in_stop | ctrl_r.stop_en);
		rst_req_nxt  = det_act_r & drst_en & det_s;
	end

	always_ff @(posedge i_clk or posedge rst_any) begin
		if (rst_any) begin
			ctrl_r    <= CTRL_RST;
			irq_r     <= 1'b0;
			det_act_r <= 1'b0;
			rst_req_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			irq_r     <= irq_nxt;
			det_act_r <= det_act_nxt;
			rst_req_r <= rst_req_nxt;
		end
	end

	always_ff @(posedge i_clk or posedge i_por) begin
		if (i_por) begin
			warn_lvl_r <= RST_WARN_LVL;
		end else begin
			warn_lvl_r <= warn_lvl_nxt;
		end
	end

	// helper state for checks only
	always_ff @(posedge i_clk or posedge rst_any) begin
		if (rst_any) begin
			c1_seen_r <= 1'b0;
			c2_seen_r <= 1'b0;
		end else begin
			c1_seen_r <= c1_seen_r | wr_c1;
			c2_seen_r <= c2_seen_r | wr_c2;
		end
	end

	assign o_awready               = awready_r;
	assign o_wready                = wready_r;
	assign o_bvalid                = bvalid_r;
	assign o_bresp                 = bresp_r;
	assign o_arready               = arready_r;
	assign o_rvalid                = rvalid_r;
	assign o_rdata                 = rdata_r;
	assign o_rresp                 = rresp_r;
	assign o_warn_irq              = irq_r;
	assign o_detect_reset_req      = rst_req_r;
	assign o_detect_active         = det_act_r;
	assign o_ref_buffer_en         = ctrl_r.ref_buf;
	assign o_detect_level_select   = det_lvl;
	assign o_warning_level_select  = warn_lvl_r;
	assign o_powerdown_mode_select = ppd_mode;

	// ---- checks ----
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (rst_any);

	id_low_read_a: assert property (i_arvalid && arready_r && rd_is_idlo |=>
		rdata_r == {24'h000000, PART_ID_LOW})
		else $error("part id low read wrong");
	warn_sticky_a: assert property (ctrl_r.warn_flag && !wr_c1 |=> ctrl_r.warn_flag)
		else $error("warning flag dropped without ack");
	warn_set_a: assert property (warn_s |=> ctrl_r.warn_flag)
		else $error("warning flag not set");
	warn_ack_hold_a: assert property (wr_c1 && wdata_r[C1_WARN_ACK] && warn_s
		|=> ctrl_r.warn_flag)
		else $error("ack cleared flag while warning active");
	warn_irq_a: assert property (##1 o_warn_irq == (ctrl_r.irq_en && ctrl_r.warn_flag))
		else $error("warning irq mismatch");
	det_reset_gate_a: assert property (!det_en || !drst_en |=> ##1 !o_detect_reset_req)
		else $error("detect reset without enables");
	det_stop_a: assert property (det_en && i_in_stop && !ctrl_r.stop_en
		|=> !o_detect_active)
		else $error("detection active in stop");
	once_det_a: assert property (c1_seen_r && wr_c1 |=> $stable(det_en) && $stable(drst_en))
		else $error("write-once control 1 bit changed");
	once_ppd_a: assert property (c2_seen_r && wr_c2 |=> $stable(ppd_mode) && $stable(det_lvl))
		else $error("write-once control 2 bit changed");
	ppd_clear_a: assert property (wr_c2 && wdata_r[C2_PPD_ACK] && !i_ppd_wake
		|=> !ctrl_r.ppd_flag)
		else $error("recovered flag not cleared");
	ppd_set_a: assert property (i_ppd_wake |=> ctrl_r.ppd_flag)
		else $error("recovered flag not set");
endmodule // pmr_power_monitor

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
	import pmr_pkg::*;
	localparam logic [7:0] ID_LO = 8'h5a; // arbitrary value
	localparam logic [3:0] ID_HI = 4'h3;  // arbitrary value
	logic              i_clk, i_rst, i_por;
	logic [ADDR_W-1:0] i_awaddr, i_araddr;
	logic              i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic [31:0]       i_wdata;
	logic [3:0]        i_wstrb;
	logic              i_warn_active, i_detect_event, i_in_stop, i_ppd_wake;
	logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]        o_bresp, o_rresp;
	logic [31:0]       o_rdata;
	logic              o_warn_irq, o_detect_reset_req, o_detect_active, o_ref_buffer_en;
	logic              o_detect_level_select, o_warning_level_select, o_powerdown_mode_select;
	int                n_fail, compares;

	pmr_power_monitor #(.PART_ID_LOW(ID_LO), .PART_ID_HIGH(ID_HI)) pmr_power_monitor_inst (
		.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.i_warn_active(i_warn_active), .i_detect_event(i_detect_event),
		.i_in_stop(i_in_stop), .i_ppd_wake(i_ppd_wake),
		.o_warn_irq(o_warn_irq), .o_detect_reset_req(o_detect_reset_req),
		.o_detect_active(o_detect_active), .o_ref_buffer_en(o_ref_buffer_en),
		.o_detect_level_select(o_detect_level_select),
		.o_warning_level_select(o_warning_level_select),
		.o_powerdown_mode_select(o_powerdown_mode_select)
	);

	initial begin
		i_clk = 1'b0;
	end
	always #25 i_clk = ~i_clk;

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// ready is sampled 1 ns after an edge, where it holds until the next edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data,
			input logic [1:0] exp_resp = RESP_OKAY, input logic [3:0] strb = 4'h1);
		bit aw_p, w_p, aw_r, w_r;
		aw_p = 1;
		w_p = 1;
		@(posedge i_clk);
		i_awaddr <= addr;
		i_awvalid <= 1'b1;
		i_wdata <= {24'h000000, data};
		i_wstrb <= strb;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (aw_p || w_p) begin
			#1;
			aw_r = o_awready;
			w_r = o_wready;
			@(posedge i_clk);
			if (aw_p && aw_r) begin
				aw_p = 0;
				i_awvalid <= 1'b0;
			end
			if (w_p && w_r) begin
				w_p = 0;
				i_wvalid <= 1'b0;
			end
		end
		forever begin
			#1;
			if (o_bvalid === 1'b1) begin
				check("bresp", {30'h0, exp_resp}, {30'h0, o_bresp});
				@(posedge i_clk);
				i_bready <= 1'b0;
				break;
			end
			@(posedge i_clk);
		end
	endtask

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string name,
			input logic [31:0] mask = 32'hffffffff, input logic [1:0] exp_resp = RESP_OKAY);
		bit ar_r;
		@(posedge i_clk);
		i_araddr <= addr;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		forever begin
			#1;
			ar_r = o_arready;
			@(posedge i_clk);
			if (ar_r) begin
				i_arvalid <= 1'b0;
				break;
			end
		end
		forever begin
			#1;
			if (o_rvalid === 1'b1) begin
				check({name, " resp"}, {30'h0, exp_resp}, {30'h0, o_rresp});
				if (exp_resp === RESP_OKAY)
					check(name, exp, o_rdata & mask);
				@(posedge i_clk);
				i_rready <= 1'b0;
				break;
			end
			@(posedge i_clk);
		end
	endtask

	task automatic do_reset(input bit por);
		@(posedge i_clk);
		i_rst <= 1'b1;
		i_por <= por;
		idle(5);
		i_rst <= 1'b0;
		i_por <= 1'b0;
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		$display("unexpected watchdog: expected done seen hang");
		conclude;
	end

	initial begin
		n_fail = 0;
		compares = 0;
		{i_rst, i_por} = 2'b11;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
		{i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
		{i_warn_active, i_detect_event, i_in_stop, i_ppd_wake} = '0;
		idle(5);
		i_rst <= 1'b0;
		i_por <= 1'b0;
		// reset values, identity and refused accesses
		rd(ADDR_ID_HIGH, {28'h0, ID_HI}, "id_high", 32'h0000000f);
		rd(ADDR_ID_LOW, {24'h0, ID_LO}, "id_low");
		wr(ADDR_ID_HIGH, 8'hff);
		wr(ADDR_ID_LOW, 8'h00);
		rd(ADDR_ID_HIGH, {28'h0, ID_HI}, "id_high", 32'h0000000f);
		rd(ADDR_ID_LOW, {24'h0, ID_LO}, "id_low");
		rd(ADDR_CTRL1, 32'h14, "ctrl1");
		rd(ADDR_CTRL2, 32'h00, "ctrl2");
		wr(8'h10, 8'hff, RESP_SLVERR);
		rd(8'h10, 32'h0, "unmapped", 32'hffffffff, RESP_SLVERR);
		check("ref_buf", 0, o_ref_buffer_en);
		check("det_active", 1, o_detect_active);
		$display("test reset_values done");
		// detect reset, detection in stop, write-once lock
		i_detect_event <= 1'b1;
		idle(8);
		check("reset_req", 1, o_detect_reset_req);
		i_in_stop <= 1'b1;
		idle(8);
		check("det_active", 0, o_detect_active);
		check("reset_req", 0, o_detect_reset_req);
		wr(ADDR_CTRL1, 8'h1c);
		idle(3);
		check("det_active", 1, o_detect_active);
		check("reset_req", 1, o_detect_reset_req);
		wr(ADDR_CTRL1, 8'h00);
		rd(ADDR_CTRL1, 32'h14, "ctrl1");
		i_in_stop <= 1'b0;
		i_detect_event <= 1'b0;
		idle(8);
		check("reset_req", 0, o_detect_reset_req);
		$display("test detect done");
		// detect logic off after a non-power-on reset
		do_reset(0);
		wr(ADDR_CTRL1, 8'h29);
		rd(ADDR_CTRL1, 32'h29, "ctrl1");
		check("ref_buf", 1, o_ref_buffer_en);
		i_detect_event <= 1'b1;
		i_in_stop <= 1'b1;
		idle(8);
		check("reset_req", 0, o_detect_reset_req);
		check("det_active", 0, o_detect_active);
		i_detect_event <= 1'b0;
		i_in_stop <= 1'b0;
		wr(ADDR_CTRL1, 8'h14);
		rd(ADDR_CTRL1, 32'h00, "ctrl1");
		check("ref_buf", 0, o_ref_buffer_en);
		$display("test detect_off done");
		// warning flag, acknowledge and interrupt
		i_warn_active <= 1'b1;
		idle(8);
		rd(ADDR_CTRL1, 32'h80, "ctrl1");
		check("irq", 0, o_warn_irq);
		wr(ADDR_CTRL1, 8'h60);
		rd(ADDR_CTRL1, 32'ha0, "ctrl1");
		check("irq", 1, o_warn_irq);
		i_warn_active <= 1'b0;
		idle(8);
		rd(ADDR_CTRL1, 32'ha0, "ctrl1");
		wr(ADDR_CTRL1, 8'h20);
		rd(ADDR_CTRL1, 32'ha0, "ctrl1");
		wr(ADDR_CTRL1, 8'h60);
		rd(ADDR_CTRL1, 32'h20, "ctrl1");
		idle(2);
		check("irq", 0, o_warn_irq);
		$display("test warning done");
		// second control register: selects, recovery flag, reset kinds
		do_reset(1);
		wr(ADDR_CTRL2, 8'h31);
		rd(ADDR_CTRL2, 32'h31, "ctrl2");
		check("det_lvl", 1, o_detect_level_select);
		check("warn_lvl", 1, o_warning_level_select);
		check("ppd_mode", 1, o_powerdown_mode_select);
		wr(ADDR_CTRL2, 8'h00);
		rd(ADDR_CTRL2, 32'h21, "ctrl2");
		@(posedge i_clk);
		i_ppd_wake <= 1'b1;
		@(posedge i_clk);
		i_ppd_wake <= 1'b0;
		idle(2);
		rd(ADDR_CTRL2, 32'h29, "ctrl2");
		wr(ADDR_CTRL2, 8'h21);
		rd(ADDR_CTRL2, 32'h29, "ctrl2");
		wr(ADDR_CTRL2, 8'h35);
		rd(ADDR_CTRL2, 32'h31, "ctrl2");
		do_reset(0);
		rd(ADDR_CTRL2, 32'h30, "ctrl2");
		check("ppd_mode", 0, o_powerdown_mode_select);
		check("warn_lvl", 1, o_warning_level_select);
		do_reset(1);
		rd(ADDR_CTRL2, 32'h00, "ctrl2");
		$display("test ctrl2 done");
		// warning already present across reset
		i_warn_active <= 1'b1;
		do_reset(0);
		idle(8);
		rd(ADDR_CTRL1, 32'h94, "ctrl1");
		i_warn_active <= 1'b0;
		$display("test warn_after_reset done");
		conclude;
	end
endmodule // tb
